// ==== verilog/pcd_pkg.sv ====
// Constants, layouts and types for the cable diagnostic register bank.
// Assumes a 100 MHz clock and a plain management register port.
// Behaviour
// - Eight-bit page selector: zero shows copper view, one serial view; resets zero.
// - Two-bit pair selector picks pair A-D for diagnostic results; resets 00, kept.
// - Three-bit amplitude code, 0.50 V to 0.85 V; resets 010, survives software reset.
// - With bypass enabled, serial link comes up after 200 ms without negotiation.
// - Bypass status reads one if link came up by timer, zero if negotiated.
// - Diagnostic enable starts the cable test only while the copper link is down.
// - Status field: 11 fail, 10 open, 01 short, 00 none on selected pair.
// - Five-bit magnitude linear: 11111 is +1 V, 10000 0 V, 00000 -1 V.
// - Eight-bit distance; metres equal 13/16 times field plus 32.
// - Distance reads all zeros when status is 00 (no fault found); a fail result keeps its distance.
package pcd_pkg;
  localparam logic [4:0] ADDR_DIAG_SEL = 5'h16;
  localparam logic [4:0] ADDR_EXT_CTL3 = 5'h1A;
  localparam logic [4:0] ADDR_EXT_STAT2 = 5'h1B;
  localparam logic [4:0] ADDR_DIAG_RES = 5'h1C;

  localparam logic [7:0] PAGE_COPPER = 8'h00;
  localparam logic [7:0] PAGE_SERIAL = 8'h01;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [4:0] RST_CTL3_UPPER = 5'h01;
  localparam logic [2:0] RST_AMP = 3'h2;
  localparam logic [2:0] RST_STAT2_TOP = 3'h4;
  localparam logic [10:0] RST_STAT2_LOW = 11'h088;
  localparam logic RST_BYPASS_EN = 1'b1;

  localparam int BIT_DIAG_EN = 15;
  localparam int BIT_BYPASS_EN = 12;
  localparam int BIT_BYPASS_STAT = 11;

  localparam logic [1:0] ST_NONE = 2'h0;
  localparam logic [1:0] ST_SHORT = 2'h1;
  localparam logic [1:0] ST_OPEN = 2'h2;
  localparam logic [1:0] ST_FAIL = 2'h3;

  localparam int CLK_MHZ = 100;
  localparam int BYPASS_MS = 200;
  localparam int BYPASS_CYCLES = BYPASS_MS * 1000 * CLK_MHZ;

  // One pair's result as the test engine delivers it
  typedef struct packed {
    logic [1:0] status;
    logic [4:0] magnitude;
    logic [7:0] distance;
  } pcd_result_t;

  typedef enum logic [1:0] {
    PCD_SER_DOWN = 2'b00,
    PCD_SER_NEG = 2'b01,
    PCD_SER_BYPASS = 2'b10
  } pcd_ser_t;
endpackage : pcd_pkg

// ==== verilog/pcd_timer.sv ====
// Run-gated counter that flags expiry after LIMIT cycles of run.
// Assumes run comes from logic on the same clock.
`timescale 1ns/10ps
module pcd_timer
  import pcd_pkg::*;
#(
  parameter int WIDTH = 25,
  parameter int LIMIT = BYPASS_CYCLES
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  output logic expired
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_expired;

  always_comb
  begin
    next_count = count;
    next_expired = expired;
    if (!run)
    begin
      next_count = '0;
      next_expired = 1'b0;
    end
    else if (count == WIDTH'(LIMIT - 1))
      next_expired = 1'b1;
    else
      next_count = count + WIDTH'(1);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      count <= '0;
      expired <= 1'b0;
    end
    else if (ce)
    begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule : pcd_timer

// ==== verilog/pcd_regs.sv ====
// Cable diagnostic and serial-side management registers.
// Assumes an external test engine and link state pins outside the clock domain.
`timescale 1ns/10ps
module pcd_regs
  import pcd_pkg::*;
#(
  parameter int BYPASS_LIMIT = BYPASS_CYCLES,
  parameter int TIMER_WIDTH = 25
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sw_reset,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic copper_link_pin,
  input wire logic serdes_signal_pin,
  input wire logic serdes_an_done_pin,
  input wire logic test_done,
  input wire pcd_result_t [3:0] test_result,
  output logic test_run,
  output logic serial_view,
  output logic [2:0] rx_amp_code,
  output logic serdes_link_up
);
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic link_q;
  logic sig_q;
  logic an_q;
  logic expired;

  logic [7:0] page;
  logic [4:0] ctl3_upper;
  logic [2:0] amp;
  logic [10:0] stat2_low;
  logic bypass_en;
  logic bypass_stat;
  pcd_ser_t ser_state;
  logic diag_en;
  pcd_result_t [3:0] result;

  logic [7:0] next_page;
  logic [4:0] next_ctl3_upper;
  logic [2:0] next_amp;
  logic [10:0] next_stat2_low;
  logic next_bypass_en;
  logic next_bypass_stat;
  pcd_ser_t next_ser_state;
  logic next_diag_en;
  pcd_result_t [3:0] next_result;
  logic next_serial_view;
  logic [15:0] next_rdata;
  pcd_result_t shown;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else if (ce)
    begin
      sync_a <= {serdes_an_done_pin, serdes_signal_pin, copper_link_pin};
      sync_b <= sync_a;
    end
  end
  assign link_q = sync_b[0];
  assign sig_q = sync_b[1];
  assign an_q = sync_b[2];

  pcd_timer #(
    .WIDTH(TIMER_WIDTH),
    .LIMIT(BYPASS_LIMIT)
  ) u_bypass_timer (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(ser_state == PCD_SER_DOWN && sig_q && bypass_en && !an_q),
    .expired(expired)
  );

  // Selected pair; pair select shares the low page bits
  always_comb
  begin
    shown = result[page[1:0]];
  end

  always_comb
  begin
    next_page = page;
    next_ctl3_upper = ctl3_upper;
    next_amp = amp;
    next_stat2_low = stat2_low;
    next_bypass_en = bypass_en;
    next_bypass_stat = bypass_stat;
    next_ser_state = ser_state;
    next_diag_en = diag_en;
    next_result = result;
    if (wr)
    begin
      case (addr)
        ADDR_DIAG_SEL: next_page = wdata[7:0];
        // Upper bits stored as written; software must echo them
        ADDR_EXT_CTL3:
        begin
          next_ctl3_upper = wdata[7:3];
          next_amp = wdata[2:0];
        end
        ADDR_EXT_STAT2:
        begin
          next_bypass_en = wdata[BIT_BYPASS_EN];
          next_stat2_low = wdata[10:0];
        end
        ADDR_DIAG_RES:
        begin
          if (!wdata[BIT_DIAG_EN])
            next_diag_en = 1'b0;
          else if (!link_q && !diag_en)
          begin
            // Start refused while link is up
            next_diag_en = 1'b1;
            next_result = '0;
          end
        end
        default: ;
      endcase
    end
    if (diag_en && test_done)
    begin
      next_diag_en = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        next_result[i] = test_result[i];
        if (test_result[i].status == ST_NONE)
          next_result[i].distance = '0;
      end
    end
    case (ser_state)
      PCD_SER_DOWN:
      begin
        if (sig_q && an_q)
        begin
          next_ser_state = PCD_SER_NEG;
          next_bypass_stat = 1'b0;
        end
        else if (sig_q && bypass_en && expired)
        begin
          next_ser_state = PCD_SER_BYPASS;
          next_bypass_stat = 1'b1;
        end
      end
      PCD_SER_NEG,
      PCD_SER_BYPASS:
        if (!sig_q)
          next_ser_state = PCD_SER_DOWN;
      default: next_ser_state = PCD_SER_DOWN;
    endcase
    // Software reset drops the test and its results; selectors are kept
    if (sw_reset)
    begin
      next_diag_en = 1'b0;
      next_result = '0;
    end
    next_serial_view = (next_page == PAGE_SERIAL);
  end

  always_comb
  begin
    next_rdata = '0;
    if (rd)
    begin
      case (addr)
        ADDR_DIAG_SEL: next_rdata = {8'h00, page};
        ADDR_EXT_CTL3: next_rdata = {8'h00, ctl3_upper, amp};
        ADDR_EXT_STAT2: next_rdata = {RST_STAT2_TOP, bypass_en, bypass_stat, stat2_low};
        ADDR_DIAG_RES: next_rdata = {diag_en, shown};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      page <= RST_PAGE;
      ctl3_upper <= RST_CTL3_UPPER;
      amp <= RST_AMP;
      stat2_low <= RST_STAT2_LOW;
      bypass_en <= RST_BYPASS_EN;
      bypass_stat <= 1'b0;
      ser_state <= PCD_SER_DOWN;
      diag_en <= 1'b0;
      result <= '0;
      serial_view <= 1'b0;
      rdata <= '0;
    end
    else if (ce)
    begin
      page <= next_page;
      ctl3_upper <= next_ctl3_upper;
      amp <= next_amp;
      stat2_low <= next_stat2_low;
      bypass_en <= next_bypass_en;
      bypass_stat <= next_bypass_stat;
      ser_state <= next_ser_state;
      diag_en <= next_diag_en;
      result <= next_result;
      serial_view <= next_serial_view;
      rdata <= next_rdata;
    end
  end

  assign test_run = diag_en;
  assign rx_amp_code = amp;
  assign serdes_link_up = (ser_state != PCD_SER_DOWN);

  a_view_decode: assert property (@(posedge clk) disable iff (!nrst)
    serial_view == (page == PAGE_SERIAL))
    else $error("page view decode wrong");

  a_pair_read: assert property (@(posedge clk) disable iff (!nrst)
    ce && rd && addr == ADDR_DIAG_RES |=> rdata[14:0] == $past(result[page[1:0]]))
    else $error("result read not from selected pair");

  a_amp_kept: assert property (@(posedge clk) disable iff (!nrst)
    ce && sw_reset && !wr |=> rx_amp_code == $past(amp))
    else $error("amplitude lost on software reset");

  a_bypass_up: assert property (@(posedge clk) disable iff (!nrst)
    ce && ser_state == PCD_SER_DOWN && sig_q && bypass_en && expired && !an_q
    |=> serdes_link_up && bypass_stat)
    else $error("bypass expiry did not raise link");

  a_neg_status: assert property (@(posedge clk) disable iff (!nrst)
    ser_state == PCD_SER_NEG |-> !bypass_stat)
    else $error("bypass status set after negotiation");

  a_start_refused: assert property (@(posedge clk) disable iff (!nrst)
    ce && !diag_en && $rose(diag_en) == 1'b0 && wr && addr == ADDR_DIAG_RES && link_q
    |=> !diag_en)
    else $error("test started with link up");

  a_dist_zero: assert property (@(posedge clk) disable iff (!nrst)
    ce && diag_en && test_done && test_result[page[1:0]].status == ST_NONE && !sw_reset
    && page == $past(page) ##1 page == $past(page) |-> shown.distance == 8'h00)
    else $error("distance not zero without fault");

  a_result_hold: assert property (@(posedge clk) disable iff (!nrst)
    !diag_en && !sw_reset && !(wr && addr == ADDR_DIAG_RES) |=> result == $past(result))
    else $error("results changed while idle");

  a_result_take: assert property (@(posedge clk) disable iff (!nrst)
    ce && diag_en && test_done && !sw_reset
    |=> result[0].status == $past(test_result[0].status) && !diag_en)
    else $error("results not captured at test end");

  a_page_write: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr && addr == ADDR_DIAG_SEL |=> page == $past(wdata[7:0]))
    else $error("page selector write lost");

  a_pair_kept: assert property (@(posedge clk) disable iff (!nrst)
    ce && sw_reset && !wr |=> page == $past(page))
    else $error("pair selector lost on software reset");

  a_amp_write: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr && addr == ADDR_EXT_CTL3 |=> rx_amp_code == $past(wdata[2:0]))
    else $error("amplitude write lost");

  a_bypass_wait: assert property (@(posedge clk) disable iff (!nrst)
    ce && ser_state == PCD_SER_DOWN && !expired && !an_q |=> !serdes_link_up)
    else $error("serial link up before timer or negotiation");

  a_bypass_flag: assert property (@(posedge clk) disable iff (!nrst)
    ser_state == PCD_SER_BYPASS |-> bypass_stat)
    else $error("bypass status clear on timer bring-up");

  a_start_ok: assert property (@(posedge clk) disable iff (!nrst)
    ce && !diag_en && !link_q && !sw_reset && wr && addr == ADDR_DIAG_RES
    && wdata[BIT_DIAG_EN] |=> diag_en && result == '0)
    else $error("test start refused with link down");

  a_mag_take: assert property (@(posedge clk) disable iff (!nrst)
    ce && diag_en && test_done && !sw_reset
    |=> result[0].magnitude == $past(test_result[0].magnitude))
    else $error("magnitude not captured at test end");

  a_dist_take: assert property (@(posedge clk) disable iff (!nrst)
    ce && diag_en && test_done && !sw_reset && test_result[1].status != ST_NONE
    |=> result[1].distance == $past(test_result[1].distance))
    else $error("distance not captured at test end");

  a_sw_clear: assert property (@(posedge clk) disable iff (!nrst)
    ce && sw_reset |=> !diag_en && result == '0)
    else $error("software reset left test or results");
endmodule : pcd_regs

// ==== verification/pcd_far_model.sv ====
// Behavioural cable test engine facing the register bank.
// Assumes the bench sets the latency (at least 1) and the per-pair results.
`timescale 1ns/10ps
module pcd_far_model
  import pcd_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic test_run,
  input wire logic [3:0] lat,
  input wire pcd_result_t [3:0] res,
  output logic test_done,
  output pcd_result_t [3:0] test_result
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_done;
  // Garbage outside the done pulse, so held results must come from the bank
  assign test_result = test_done ? res : ~res;
  always_comb
  begin
    next_cnt = cnt + 4'h1;
    next_done = (next_cnt == lat);
    if (!test_run || test_done)
    begin
      next_cnt = 4'h0;
      next_done = 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt <= 4'h0;
      test_done <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      test_done <= next_done;
    end
  end
endmodule : pcd_far_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the cable diagnostic register bank.
// Assumes the far model as test engine and a short bypass timer.
`timescale 1ns/10ps
module tb_top
  import pcd_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sw_reset = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cu_link = 1'b0;
  logic ser_sig = 1'b0;
  logic ser_done = 1'b0;
  logic [3:0] lat = 4'h9;
  pcd_result_t [3:0] res;
  pcd_result_t [3:0] test_result;
  logic [15:0] rdata;
  logic [2:0] rx_amp_code;
  logic test_done, test_run, serial_view, serdes_link_up;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  always #5 clk = ~clk;
  pcd_regs #(.BYPASS_LIMIT(20), .TIMER_WIDTH(25)) dut (.clk(clk), .nrst(nrst), .ce(1'b1),
    .sw_reset(sw_reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .copper_link_pin(cu_link), .serdes_signal_pin(ser_sig), .serdes_an_done_pin(ser_done),
    .test_done(test_done), .test_result(test_result), .test_run(test_run),
    .serial_view(serial_view), .rx_amp_code(rx_amp_code), .serdes_link_up(serdes_link_up));
  pcd_far_model far (.clk(clk), .nrst(nrst), .test_run(test_run), .lat(lat), .res(res),
    .test_done(test_done), .test_result(test_result));
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write_reg
  task automatic read_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : read_chk
  function automatic logic [15:0] exp_res(input pcd_result_t r);
    return {1'b0, r.status, r.magnitude, (r.status == ST_NONE) ? 8'h00 : r.distance};
  endfunction : exp_res
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 4000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    res[0] = {ST_SHORT, 5'h1F, 8'h20};
    res[1] = {ST_OPEN, 5'h10, 8'h45};
    res[2] = {ST_FAIL, 5'h00, 8'h00};
    res[3] = {ST_NONE, 5'h10, 8'h99};
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    read_chk(ADDR_DIAG_SEL, 16'h0000);
    read_chk(ADDR_EXT_CTL3, 16'h000A);
    read_chk(ADDR_EXT_STAT2, 16'h9088);
    read_chk(ADDR_DIAG_RES, 16'h0000);
    read_chk(5'h00, 16'h0000);
    check(rx_amp_code, 3'h2);
    write_reg(ADDR_EXT_CTL3, 16'h000F);
    read_chk(ADDR_EXT_CTL3, 16'h000F);
    check(rx_amp_code, 3'h7);
    write_reg(ADDR_DIAG_RES, 16'h8000);
    #1 check(test_run, 1'b1);
    write_reg(ADDR_DIAG_RES, 16'h0000);
    read_chk(ADDR_DIAG_RES, 16'h0000);
    check(test_run, 1'b0);
    lat <= 4'h1;
    write_reg(ADDR_DIAG_RES, 16'h8000);
    #1;
    for (i = 0; i < 20 && test_run !== 1'b0; i++) @(posedge clk) #1;
    check(test_run, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      write_reg(ADDR_DIAG_SEL, 16'(p));
      read_chk(ADDR_DIAG_RES, exp_res(res[p]));
      check(serial_view, p == 1);
    end
    repeat (20) @(posedge clk);
    read_chk(ADDR_DIAG_RES, exp_res(res[3]));
    // Link up must refuse a new start
    cu_link <= 1'b1;
    repeat (4) @(posedge clk);
    write_reg(ADDR_DIAG_RES, 16'h8000);
    #1 check(test_run, 1'b0);
    cu_link <= 1'b0;
    @(posedge clk);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    read_chk(ADDR_DIAG_RES, 16'h0000);
    read_chk(ADDR_EXT_CTL3, 16'h000F);
    read_chk(ADDR_DIAG_SEL, 16'h0003);
    // Fault-free pair selected while the test ends
    write_reg(ADDR_DIAG_RES, 16'h8000);
    #1;
    for (i = 0; i < 20 && test_run !== 1'b0; i++) @(posedge clk) #1;
    check(test_run, 1'b0);
    read_chk(ADDR_DIAG_RES, exp_res(res[3]));
    ser_sig <= 1'b1;
    repeat (15) @(posedge clk);
    #1 check(serdes_link_up, 1'b0);
    for (i = 0; i < 30 && serdes_link_up !== 1'b1; i++) @(posedge clk) #1;
    check(serdes_link_up, 1'b1);
    read_chk(ADDR_EXT_STAT2, 16'h9888);
    ser_sig <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check(serdes_link_up, 1'b0);
    write_reg(ADDR_EXT_STAT2, 16'h8088);
    ser_sig <= 1'b1;
    repeat (40) @(posedge clk);
    #1 check(serdes_link_up, 1'b0);
    ser_done <= 1'b1;
    for (i = 0; i < 10 && serdes_link_up !== 1'b1; i++) @(posedge clk) #1;
    check(serdes_link_up, 1'b1);
    read_chk(ADDR_EXT_STAT2, 16'h8088);
    give_verdict();
  end
endmodule : tb_top
